// *** include/cmt_pkg.sv ***
`default_nettype none
package cmt_pkg;
	// Base tick of the timers is 80 ns, made from the 50 ns core clock.
	localparam int CLK_PERIOD_NS = 50;
	localparam int BASE_TICK_NS = 80;
	localparam int ACC_W = 8;
	localparam logic [ACC_W-1:0] TICK_STEP = ACC_W'(CLK_PERIOD_NS);
	localparam logic [ACC_W-1:0] TICK_WRAP = ACC_W'(BASE_TICK_NS);
	localparam int TMR_W = 16;
	localparam int PRE_BUS_W = 8;
	localparam int PACE_PRE_W = 8;
	localparam int NOISE_PRE_W = 2;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam int IDX_W = 6;
	localparam int IDX_LSB = 2;
	// Register indices; the byte address is four times the index.
	localparam logic [IDX_W-1:0] IDX_CTRL_A = 6'h00;
	localparam logic [IDX_W-1:0] IDX_TX_VECTOR = 6'h03;
	localparam logic [IDX_W-1:0] IDX_VEC_LEN = 6'h04;
	localparam logic [IDX_W-1:0] IDX_PACE_PRELOAD = 6'h0E;
	localparam logic [IDX_W-1:0] IDX_NOISE_PRELOAD = 6'h0F;
	localparam logic [IDX_W-1:0] IDX_STATUS_B = 6'h11;
	localparam logic [IDX_W-1:0] IDX_PACE_COUNT = 6'h12;
	localparam logic [IDX_W-1:0] IDX_NOISE_COUNT = 6'h13;
	localparam logic [IDX_W-1:0] IDX_PRESCALE = 6'h14;
	localparam logic [IDX_W-1:0] IDX_EVENT = 6'h18;
	// Control register A fields.
	localparam int CTRL_W = 3;
	localparam int CTRL_PACE_FAST = 0;
	localparam int CTRL_NOISE_FAST = 1;
	localparam int CTRL_NOISE_AUTO = 2;
	// Status register B fields.
	localparam int STB_CAUSE_LSB = 0;
	localparam int STB_TX_CODE = 3;
	localparam int STB_RX_CODE = 4;
	localparam int STB_SEEN = 5;
	localparam int STB_SIGNALING = 6;
	localparam int STB_STATE_LSB = 7;
	localparam int PRE_NOISE_LSB = 8;
	localparam int EVT_HOST_ERR = 0;
	localparam int VEC_LEN_W = 4;
	// Connection manager state codes seen on the state input.
	localparam logic [3:0] PCM_NEXT = 4'h4;
	localparam logic [3:0] PCM_ACTIVE = 4'h8;
	localparam logic [3:0] PCM_MAINTENANCE = 4'h9;
	localparam logic [3:0] PCM_OFF = 4'h0;
	typedef enum logic [2:0] {
		CAUSE_NEVER = 3'b000,
		CAUSE_START = 3'b001,
		CAUSE_PACE = 3'b010,
		CAUSE_NOISE = 3'b011,
		CAUSE_QUIET = 3'b100,
		CAUSE_IDLE = 3'b101,
		CAUSE_HALT = 3'b110,
		CAUSE_RSVD = 3'b111
	} cmt_break_type;
endpackage : cmt_pkg
`default_nettype wire

// *** include/cmt_timer_if.sv ***
`default_nettype none
interface cmt_timer_if;
	logic load;
	logic [cmt_pkg::TMR_W-1:0] load_value;
	logic run;
	logic fast;
	logic tick;
	logic [cmt_pkg::TMR_W-1:0] count;
	logic [cmt_pkg::PRE_BUS_W-1:0] prescale;
	logic expired;
	modport timer(input load, load_value, run, fast, tick,
		output count, prescale, expired);
	modport ctrl(output load, load_value, run, fast, tick,
		input count, prescale, expired);
endinterface : cmt_timer_if
`default_nettype wire

// *** core/cmt_tick_gen.sv ***
`default_nettype none
module cmt_tick_gen (
	input wire logic clk_in,
	input wire logic rst_in,
	output logic tick_out
);
	typedef struct packed {
		logic [cmt_pkg::ACC_W-1:0] acc;
		logic tick;
	} cmt_tick_state_type;
	cmt_tick_state_type s_q;
	cmt_tick_state_type s_d;
	logic [cmt_pkg::ACC_W-1:0] sum;

	// Phase accumulator: five ticks in every eight clocks average 80 ns.
	// The jitter of one clock period (50 ns) stays below one 80 ns base tick, the fast-mode resolution.
	always_comb begin
		s_d = s_q;
		sum = s_q.acc + cmt_pkg::TICK_STEP;
		s_d.tick = 1'b0;
		if (sum >= cmt_pkg::TICK_WRAP) begin
			s_d.acc = sum - cmt_pkg::TICK_WRAP;
			s_d.tick = 1'b1;
		end else begin
			s_d.acc = sum;
		end
	end

	// State register.
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tick_out = s_q.tick;
endmodule : cmt_tick_gen
`default_nettype wire

// *** core/cmt_timer.sv ***
`default_nettype none
module cmt_timer #(
	parameter int PRE_W = 8
) (
	input wire logic clk_in,
	input wire logic rst_in,
	cmt_timer_if.timer tif
);
	localparam logic [PRE_W-1:0] PRE_MAX = '1;
	typedef struct packed {
		logic [cmt_pkg::TMR_W-1:0] count;
		logic [PRE_W-1:0] pre;
		logic done;
		logic expired;
	} cmt_tmr_state_type;
	cmt_tmr_state_type s_q;
	cmt_tmr_state_type s_d;

	// A load restarts the count; once zero is reached the timer stays put.
	always_comb begin
		s_d = s_q;
		s_d.expired = 1'b0;
		if (tif.load) begin
			s_d.count = tif.load_value;
			s_d.pre = '0;
			s_d.done = 1'b0;
		end else if (tif.tick && tif.run && !s_q.done) begin
			if (tif.fast || (s_q.pre == PRE_MAX)) begin
				s_d.pre = '0;
				s_d.count = s_q.count + 1'b1;
				if (s_d.count == '0) begin
					s_d.done = 1'b1;
					s_d.expired = 1'b1;
				end
			end else begin
				s_d.pre = s_q.pre + 1'b1;
			end
		end
	end

	// State register; everything clears on hardware reset.
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tif.count = s_q.count;
	assign tif.prescale = cmt_pkg::PRE_BUS_W'(s_q.pre);
	assign tif.expired = s_q.expired;
endmodule : cmt_timer
`default_nettype wire

// *** core/cmt_conn_timers.sv ***
`default_nettype none
module cmt_conn_timers (
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [cmt_pkg::ADDR_W-1:0] paddr_in,
	input wire logic [cmt_pkg::DATA_W-1:0] pwdata_in,
	output logic [cmt_pkg::DATA_W-1:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic [3:0] pcm_state_in,
	input wire logic pace_load_in,
	input wire logic [cmt_pkg::TMR_W-1:0] pace_param_in,
	input wire logic response_expected_in,
	input wire logic lsm_leave_idle_in,
	input wire logic line_idle_in,
	input wire logic [cmt_pkg::TMR_W-1:0] noise_limit_in,
	input wire logic line_state_seen_in,
	input wire logic rx_code_start_in,
	input wire logic tx_code_start_in,
	input wire logic signal_done_in,
	input wire logic break_enter_in,
	input wire logic [2:0] break_cause_in,
	output logic [cmt_pkg::TMR_W-1:0] tx_vector_out,
	output logic [cmt_pkg::VEC_LEN_W-1:0] vector_length_out,
	output logic signaling_out,
	output logic line_state_seen_out,
	output logic rx_code_started_out,
	output logic tx_code_started_out,
	output logic pace_expired_out,
	output logic noise_expired_out,
	output logic break_req_out,
	output logic [2:0] break_req_cause_out,
	output logic host_access_error_out
);
	typedef struct packed {
		logic [cmt_pkg::CTRL_W-1:0] ctrl;
		logic [cmt_pkg::TMR_W-1:0] tx_vector;
		logic [cmt_pkg::VEC_LEN_W-1:0] vec_len;
		logic signaling;
		logic seen;
		logic rx_code;
		logic tx_code;
		logic [2:0] cause;
		logic [3:0] prev_state;
		logic host_err;
		logic noise_run;
		logic [cmt_pkg::DATA_W-1:0] prdata;
		logic pready;
		logic pslverr;
		logic break_req;
		logic [2:0] break_cause;
	} cmt_top_state_type;

	cmt_top_state_type s_q;
	cmt_top_state_type s_d;
	cmt_timer_if pace_if();
	cmt_timer_if noise_if();
	logic tick;
	logic [cmt_pkg::IDX_W-1:0] idx;
	logic setup;
	logic wr_fire;
	logic in_maintenance_state;
	logic noise_auto;
	logic pace_host_ok;
	logic pace_host_bad;
	logic noise_host_ok;
	logic noise_host_bad;
	logic vec_bad;
	logic noise_hw_load;
	logic state_change;
	logic err_set;

	// Word index of an address; both phases decode it the same way.
	function automatic logic [cmt_pkg::IDX_W-1:0] word_index(
		input logic [cmt_pkg::ADDR_W-1:0] addr
	);
		word_index = addr[cmt_pkg::ADDR_W-1:cmt_pkg::IDX_LSB];
	endfunction : word_index

	// True for every index that answers without an error.
	function automatic logic is_mapped(
		input logic [cmt_pkg::IDX_W-1:0] i
	);
		unique case (i)
			cmt_pkg::IDX_CTRL_A,
			cmt_pkg::IDX_TX_VECTOR,
			cmt_pkg::IDX_VEC_LEN,
			cmt_pkg::IDX_PACE_PRELOAD,
			cmt_pkg::IDX_NOISE_PRELOAD,
			cmt_pkg::IDX_STATUS_B,
			cmt_pkg::IDX_PACE_COUNT,
			cmt_pkg::IDX_NOISE_COUNT,
			cmt_pkg::IDX_PRESCALE,
			cmt_pkg::IDX_EVENT: is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	endfunction : is_mapped

	// Shared 80 ns base tick for both prescalers.
	cmt_tick_gen u_tick (
		.clk_in(core_clk_in),
		.rst_in(sys_rst_in),
		.tick_out(tick)
	);

	cmt_timer #(
		.PRE_W(cmt_pkg::PACE_PRE_W)
	) u_pace (
		.clk_in(core_clk_in),
		.rst_in(sys_rst_in),
		.tif(pace_if)
	);

	cmt_timer #(
		.PRE_W(cmt_pkg::NOISE_PRE_W)
	) u_noise (
		.clk_in(core_clk_in),
		.rst_in(sys_rst_in),
		.tif(noise_if)
	);

	// Bus decode. A write lands only on the access edge with pready high.
	assign idx = word_index(paddr_in);
	assign setup = psel_in && !penable_in;
	assign wr_fire = psel_in && penable_in && s_q.pready && pwrite_in;
	assign in_maintenance_state = (pcm_state_in == cmt_pkg::PCM_MAINTENANCE);
	assign noise_auto = s_q.ctrl[cmt_pkg::CTRL_NOISE_AUTO];
	assign state_change = (pcm_state_in != s_q.prev_state);

	// Host preloads are checked against the manager state at write time.
	assign pace_host_ok = wr_fire && (idx == cmt_pkg::IDX_PACE_PRELOAD)
		&& in_maintenance_state;
	assign pace_host_bad = wr_fire && (idx == cmt_pkg::IDX_PACE_PRELOAD)
		&& !in_maintenance_state;
	assign noise_host_ok = wr_fire && (idx == cmt_pkg::IDX_NOISE_PRELOAD)
		&& in_maintenance_state && !noise_auto;
	assign noise_host_bad = wr_fire && (idx == cmt_pkg::IDX_NOISE_PRELOAD)
		&& !(in_maintenance_state && !noise_auto);
	assign vec_bad = wr_fire && s_q.signaling
		&& ((idx == cmt_pkg::IDX_TX_VECTOR)
		|| (idx == cmt_pkg::IDX_VEC_LEN));
	assign err_set = pace_host_bad || noise_host_bad || vec_bad;

	// In maintenance the line only reloads the noise timer in auto mode,
	// so a host preload there is not overwritten behind its back.
	assign noise_hw_load = lsm_leave_idle_in
		&& (!in_maintenance_state || noise_auto);

	// Pacing timer drive; a manager load and a host load share one port.
	assign pace_if.load = pace_load_in || pace_host_ok;
	assign pace_if.load_value = pace_host_ok ?
		pwdata_in[cmt_pkg::TMR_W-1:0] : pace_param_in;
	assign pace_if.run = 1'b1;
	assign pace_if.fast = s_q.ctrl[cmt_pkg::CTRL_PACE_FAST];
	assign pace_if.tick = tick;

	// Noise timer drive.
	assign noise_if.load = noise_hw_load || noise_host_ok;
	assign noise_if.load_value = noise_host_ok ?
		pwdata_in[cmt_pkg::TMR_W-1:0] : noise_limit_in;
	assign noise_if.run = s_q.noise_run || noise_if.load;
	assign noise_if.fast = s_q.ctrl[cmt_pkg::CTRL_NOISE_FAST];
	assign noise_if.tick = tick;

	// Next-state logic for registers, flags and the bus answer.
	always_comb begin
		s_d = s_q;
		s_d.prev_state = pcm_state_in;
		s_d.break_req = 1'b0;

		// Bus answer is prepared in setup so it can come from a flop.
		if (setup) begin
			s_d.pready = 1'b1;
			s_d.pslverr = !is_mapped(idx);
			s_d.prdata = '0;
			unique case (idx)
				cmt_pkg::IDX_CTRL_A: begin
					s_d.prdata[cmt_pkg::CTRL_W-1:0] = s_q.ctrl;
				end
				cmt_pkg::IDX_TX_VECTOR: begin
					s_d.prdata[cmt_pkg::TMR_W-1:0] = s_q.tx_vector;
				end
				cmt_pkg::IDX_VEC_LEN: begin
					s_d.prdata[cmt_pkg::VEC_LEN_W-1:0] = s_q.vec_len;
				end
				cmt_pkg::IDX_STATUS_B: begin
					s_d.prdata[cmt_pkg::STB_STATE_LSB +: 4] = pcm_state_in;
					s_d.prdata[cmt_pkg::STB_SIGNALING] = s_q.signaling;
					s_d.prdata[cmt_pkg::STB_SEEN] = s_q.seen;
					s_d.prdata[cmt_pkg::STB_RX_CODE] = s_q.rx_code;
					s_d.prdata[cmt_pkg::STB_TX_CODE] = s_q.tx_code;
					s_d.prdata[cmt_pkg::STB_CAUSE_LSB +: 3] = s_q.cause;
				end
				cmt_pkg::IDX_PACE_COUNT: begin
					s_d.prdata[cmt_pkg::TMR_W-1:0] = pace_if.count;
				end
				cmt_pkg::IDX_NOISE_COUNT: begin
					s_d.prdata[cmt_pkg::TMR_W-1:0] = noise_if.count;
				end
				cmt_pkg::IDX_PRESCALE: begin
					s_d.prdata[cmt_pkg::PACE_PRE_W-1:0] =
						pace_if.prescale[cmt_pkg::PACE_PRE_W-1:0];
					s_d.prdata[cmt_pkg::PRE_NOISE_LSB +: cmt_pkg::NOISE_PRE_W] =
						noise_if.prescale[cmt_pkg::NOISE_PRE_W-1:0];
				end
				cmt_pkg::IDX_EVENT: begin
					s_d.prdata[cmt_pkg::EVT_HOST_ERR] = s_q.host_err;
				end
				default: begin
					s_d.prdata = '0;
				end
			endcase
		end else if (psel_in && penable_in && s_q.pready) begin
			s_d.pready = 1'b0;
			s_d.pslverr = 1'b0;
		end

		// Control register and signalling vector writes.
		if (wr_fire && (idx == cmt_pkg::IDX_CTRL_A)) begin
			s_d.ctrl = pwdata_in[cmt_pkg::CTRL_W-1:0];
		end
		if (wr_fire && !s_q.signaling
			&& (idx == cmt_pkg::IDX_VEC_LEN)) begin
			s_d.vec_len = pwdata_in[cmt_pkg::VEC_LEN_W-1:0];
		end

		// Signalling clears when the manager is done; a vector write made while it is still set is refused.
		if (signal_done_in) begin
			s_d.signaling = 1'b0;
		end
		if (wr_fire && !s_q.signaling
			&& (idx == cmt_pkg::IDX_TX_VECTOR)) begin
			s_d.tx_vector = pwdata_in[cmt_pkg::TMR_W-1:0];
			s_d.signaling = 1'b1;
		end

		// Per-state flags clear on a state change; a same-cycle set wins.
		if (state_change) begin
			s_d.seen = 1'b0;
			s_d.rx_code = 1'b0;
			s_d.tx_code = 1'b0;
		end
		if (line_state_seen_in) begin
			s_d.seen = 1'b1;
		end
		if (rx_code_start_in) begin
			s_d.rx_code = 1'b1;
		end
		if (tx_code_start_in) begin
			s_d.tx_code = 1'b1;
		end

		// The cause of the last break entry stays until the next one.
		if (break_enter_in) begin
			s_d.cause = break_cause_in;
		end

		// Host access error: write one clears it, a new error wins.
		if (wr_fire && (idx == cmt_pkg::IDX_EVENT)
			&& pwdata_in[cmt_pkg::EVT_HOST_ERR]) begin
			s_d.host_err = 1'b0;
		end
		if (err_set) begin
			s_d.host_err = 1'b1;
		end

		// Noise timing runs from a load until idle line state returns.
		if (line_idle_in && !noise_if.load) begin
			s_d.noise_run = 1'b0;
		end
		if (noise_if.load) begin
			s_d.noise_run = 1'b1;
		end

		// Break requests to the manager; noise has priority in ACTIVE.
		if (noise_if.expired && !line_idle_in
			&& (pcm_state_in == cmt_pkg::PCM_ACTIVE)) begin
			s_d.break_req = 1'b1;
			s_d.break_cause = cmt_pkg::CAUSE_NOISE;
		end else if (pace_if.expired && response_expected_in) begin
			s_d.break_req = 1'b1;
			s_d.break_cause = cmt_pkg::CAUSE_PACE;
		end
	end

	// State register. The previous state resets to OFF, the reset state
	// of the manager, so no false change is seen after reset.
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			s_q <= '0;
			s_q.prev_state <= cmt_pkg::PCM_OFF;
			s_q.cause <= cmt_pkg::CAUSE_NEVER;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs, all from flops of this module or of the timers.
	assign prdata_out = s_q.prdata;
	assign pready_out = s_q.pready;
	assign pslverr_out = s_q.pslverr;
	assign tx_vector_out = s_q.tx_vector;
	assign vector_length_out = s_q.vec_len;
	assign signaling_out = s_q.signaling;
	assign line_state_seen_out = s_q.seen;
	assign rx_code_started_out = s_q.rx_code;
	assign tx_code_started_out = s_q.tx_code;
	assign pace_expired_out = pace_if.expired;
	assign noise_expired_out = noise_if.expired;
	assign break_req_out = s_q.break_req;
	assign break_req_cause_out = s_q.break_cause;
	assign host_access_error_out = s_q.host_err;
endmodule : cmt_conn_timers
`default_nettype wire

// *** tb/cmt_props.sv ***
`default_nettype none
// Port-level checks of the connection timers; sees only the top ports.
module cmt_props (
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [cmt_pkg::ADDR_W-1:0] paddr_in,
	input wire logic pready_out,
	input wire logic [3:0] pcm_state_in,
	input wire logic response_expected_in,
	input wire logic line_idle_in,
	input wire logic line_state_seen_in,
	input wire logic rx_code_start_in,
	input wire logic tx_code_start_in,
	input wire logic signaling_out,
	input wire logic line_state_seen_out,
	input wire logic rx_code_started_out,
	input wire logic tx_code_started_out,
	input wire logic pace_expired_out,
	input wire logic noise_expired_out,
	input wire logic break_req_out,
	input wire logic [2:0] break_req_cause_out,
	input wire logic host_access_error_out
);
	logic wr_acc;
	// A write lands only at the edge where the access phase is answered.
	assign wr_acc = psel_in && penable_in && pready_out && pwrite_in;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (sys_rst_in);
	AST_READY_NEXT: assert property (psel_in && !penable_in |=> pready_out)
		else $error("no ready one cycle after setup");
	AST_READY_PULSE: assert property (pready_out |=> !pready_out)
		else $error("ready held longer than one cycle");
	AST_SIG_SET: assert property (
		wr_acc && paddr_in == 8'h0C && !signaling_out |=> signaling_out)
		else $error("vector write did not raise signalling");
	AST_SEEN_CLR: assert property (
		$changed(pcm_state_in) && !line_state_seen_in
		|=> !line_state_seen_out)
		else $error("seen flag survived a state change");
	AST_RX_SET: assert property (
		rx_code_start_in |=> rx_code_started_out)
		else $error("receive code flag not set");
	AST_TX_SET: assert property (
		tx_code_start_in |=> tx_code_started_out)
		else $error("transmit code flag not set");
	AST_PACE_ERR: assert property (
		wr_acc && paddr_in == 8'h38
		&& pcm_state_in != cmt_pkg::PCM_MAINTENANCE
		|=> host_access_error_out)
		else $error("refused pacing preload not flagged");
	AST_NOISE_BREAK: assert property (
		noise_expired_out && !line_idle_in
		&& pcm_state_in == cmt_pkg::PCM_ACTIVE
		|=> break_req_out && break_req_cause_out == 3'h3)
		else $error("noise expiry did not request break");
	AST_PACE_BREAK: assert property (
		pace_expired_out && response_expected_in && !noise_expired_out
		|=> break_req_out && break_req_cause_out == 3'h2)
		else $error("signalling timeout did not request break");
	AST_EXPIRE_ONCE: assert property (
		pace_expired_out |=> !pace_expired_out [*4])
		else $error("pacing expiry repeated");
endmodule : cmt_props
`default_nettype wire

// *** tb/cmt_host_model.sv ***
`default_nettype none
// Node processor model: the APB master that faces the block.
module cmt_host_model (
	input wire logic clk_in,
	input wire logic [31:0] prdata_in,
	input wire logic pready_in,
	input wire logic pslverr_in,
	output logic psel_out,
	output logic penable_out,
	output logic pwrite_out,
	output logic [7:0] paddr_out,
	output logic [31:0] pwdata_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// Idle bus from time zero.
	initial begin
		psel_out = 1'b0;
		penable_out = 1'b0;
		pwrite_out = 1'b0;
		paddr_out = 8'h00;
		pwdata_out = 32'h0;
	end
	// One transfer; ok stays low if the slave never answers, so the
	// caller can end the run instead of hanging.
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e,
		output logic ok);
		int n;
		n = 0;
		ok = 1'b0;
		@(posedge clk_in);
		psel_out <= 1'b1;
		pwrite_out <= w;
		paddr_out <= a;
		pwdata_out <= d;
		@(posedge clk_in);
		penable_out <= 1'b1;
		while (!ok && n < 16) begin
			@(posedge clk_in);
			ok = (pready_in === 1'b1);
			n++;
		end
		q = prdata_in;
		e = pslverr_in;
		psel_out <= 1'b0;
		penable_out <= 1'b0;
	endtask : xfer
endmodule : cmt_host_model
`default_nettype wire

// *** tb/tb_top.sv ***
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
	logic [7:0] paddr_in;
	logic [31:0] pwdata_in, prdata_out;
	logic [3:0] pcm_state_in = 4'h0;
	logic pace_load_in = 1'b0, response_expected_in = 1'b0;
	logic lsm_leave_idle_in = 1'b0, line_idle_in = 1'b0;
	logic [15:0] pace_param_in = 16'h0, noise_limit_in = 16'h0;
	logic line_state_seen_in = 1'b0, rx_code_start_in = 1'b0;
	logic tx_code_start_in = 1'b0, signal_done_in = 1'b0;
	logic break_enter_in = 1'b0;
	logic [2:0] break_cause_in = 3'h0, break_req_cause_out;
	logic [15:0] tx_vector_out;
	logic [3:0] vector_length_out;
	logic signaling_out, line_state_seen_out, rx_code_started_out;
	logic tx_code_started_out, pace_expired_out, noise_expired_out;
	logic break_req_out, host_access_error_out, last_err;
	int bad_count = 0;
	int tests_run = 0;
	// 50 ns clock.
	always #25 core_clk_in = ~core_clk_in;
	cmt_conn_timers i_dut (.core_clk_in, .sys_rst_in, .psel_in,
		.penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out,
		.pready_out, .pslverr_out, .pcm_state_in, .pace_load_in,
		.pace_param_in, .response_expected_in, .lsm_leave_idle_in,
		.line_idle_in, .noise_limit_in, .line_state_seen_in,
		.rx_code_start_in, .tx_code_start_in, .signal_done_in,
		.break_enter_in, .break_cause_in, .tx_vector_out,
		.vector_length_out, .signaling_out, .line_state_seen_out,
		.rx_code_started_out, .tx_code_started_out, .pace_expired_out,
		.noise_expired_out, .break_req_out, .break_req_cause_out,
		.host_access_error_out);
	cmt_host_model i_host (.clk_in(core_clk_in), .prdata_in(prdata_out),
		.pready_in(pready_out), .pslverr_in(pslverr_out),
		.psel_out(psel_in), .penable_out(penable_in),
		.pwrite_out(pwrite_in), .paddr_out(paddr_in),
		.pwdata_out(pwdata_in));
	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : results
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: seen %h expected %h", $time,
				seen, exp);
		end
	endtask : check
	task automatic acc(input logic w, input logic [5:0] i,
		input logic [31:0] d, output logic [31:0] q);
		logic ok;
		i_host.xfer(w, {i, 2'b00}, d, q, last_err, ok);
		// The write lands at the access edge; let it settle before
		// the caller compares any output.
		@(posedge core_clk_in);
		if (!ok) begin
			bad_count++;
			results();
		end
	endtask : acc
	task automatic wr(input logic [5:0] i, input logic [31:0] d);
		logic [31:0] q;
		acc(1'b1, i, d, q);
	endtask : wr
	task automatic rd(input logic [5:0] i, output logic [31:0] q);
		acc(1'b0, i, 32'h0, q);
	endtask : rd
	// Strobe masks; several strobes in one call share the same edge.
	localparam logic [6:0] P_LOAD = 7'h40;
	localparam logic [6:0] P_LEAVE = 7'h20;
	localparam logic [6:0] P_SEEN = 7'h10;
	localparam logic [6:0] P_RX = 7'h08;
	localparam logic [6:0] P_TX = 7'h04;
	localparam logic [6:0] P_DONE = 7'h02;
	localparam logic [6:0] P_BRK = 7'h01;
	// One-cycle strobe on the chosen manager inputs, set at a rising edge.
	task automatic pulse(input logic [6:0] k);
		{pace_load_in, lsm_leave_idle_in, line_state_seen_in,
			rx_code_start_in, tx_code_start_in, signal_done_in,
			break_enter_in} <= k;
		@(posedge core_clk_in);
		{pace_load_in, lsm_leave_idle_in, line_state_seen_in,
			rx_code_start_in, tx_code_start_in, signal_done_in,
			break_enter_in} <= 7'h00;
	endtask : pulse
	// Bounded wait; running out of cycles ends the run as a mismatch.
	task automatic wait_hi(ref logic s, input int lim, output int n);
		n = 0;
		while (s !== 1'b1 && n < lim) begin
			@(posedge core_clk_in);
			n++;
		end
		if (n >= lim) begin
			bad_count++;
			results();
		end
	endtask : wait_hi
	// Cycles for a count of base ticks, allowing tick jitter and flops.
	function automatic logic [31:0] near(input int n, input int ticks);
		int e;
		e = ticks * cmt_pkg::BASE_TICK_NS / cmt_pkg::CLK_PERIOD_NS;
		return 32'(n >= e - 3 && n <= e + 4);
	endfunction : near
	initial begin
		int n;
		logic [31:0] q;
		repeat (8) @(posedge core_clk_in);
		sys_rst_in <= 1'b0;
		rd(cmt_pkg::IDX_STATUS_B, q);
		check(q, 32'h0);
		rd(cmt_pkg::IDX_NOISE_COUNT, q);
		check(q, 32'h0);
		rd(6'h07, q);
		check(32'(last_err), 32'h1);
		$display("test reset done");
		wr(cmt_pkg::IDX_PACE_PRELOAD, 32'hFFF0);
		check(32'(host_access_error_out), 32'h1);
		wr(cmt_pkg::IDX_EVENT, 32'h1);
		check(32'(host_access_error_out), 32'h0);
		wr(cmt_pkg::IDX_NOISE_PRELOAD, 32'hFFF0);
		check(32'(host_access_error_out), 32'h1);
		rd(cmt_pkg::IDX_NOISE_COUNT, q);
		check(q, 32'h0);
		wr(cmt_pkg::IDX_EVENT, 32'h1);
		$display("test refused preload done");
		wr(cmt_pkg::IDX_VEC_LEN, 32'h5);
		wr(cmt_pkg::IDX_TX_VECTOR, 32'hA5A5);
		check(32'(signaling_out), 32'h1);
		wr(cmt_pkg::IDX_TX_VECTOR, 32'h1234);
		wr(cmt_pkg::IDX_VEC_LEN, 32'h9);
		check(32'(tx_vector_out), 32'hA5A5);
		check(32'(vector_length_out), 32'h5);
		check(32'(host_access_error_out), 32'h1);
		pulse(P_DONE);
		wr(cmt_pkg::IDX_EVENT, 32'h1);
		check(32'(signaling_out), 32'h0);
		$display("test vector done");
		pcm_state_in <= cmt_pkg::PCM_NEXT;
		pulse(P_SEEN | P_RX | P_TX);
		rd(cmt_pkg::IDX_STATUS_B, q);
		check(q, 32'h238);
		pcm_state_in <= 4'h5;
		rd(cmt_pkg::IDX_STATUS_B, q);
		check(q, 32'h280);
		for (int c = 0; c < 8; c++) begin
			break_cause_in <= 3'(c);
			pulse(P_BRK);
			rd(cmt_pkg::IDX_STATUS_B, q);
			check(q & 32'h7, 32'(c));
		end
		$display("test status done");
		pcm_state_in <= cmt_pkg::PCM_MAINTENANCE;
		response_expected_in <= 1'b1;
		wr(cmt_pkg::IDX_CTRL_A, 32'h1);
		wr(cmt_pkg::IDX_PACE_PRELOAD, 32'hFFF0);
		wait_hi(pace_expired_out, 100, n);
		check(near(n, 16), 32'h1);
		wait_hi(break_req_out, 4, n);
		check(32'(break_req_cause_out), 32'h2);
		response_expected_in <= 1'b0;
		rd(cmt_pkg::IDX_PACE_COUNT, q);
		check(q, 32'h0);
		wr(cmt_pkg::IDX_CTRL_A, 32'h0);
		wr(cmt_pkg::IDX_PACE_PRELOAD, 32'hFFFF);
		rd(cmt_pkg::IDX_PACE_COUNT, q);
		check(q, 32'hFFFF);
		rd(cmt_pkg::IDX_PRESCALE, q);
		check(32'(q[7:0] < 8'h10), 32'h1);
		wr(cmt_pkg::IDX_PACE_PRELOAD, 32'hFFFF);
		wait_hi(pace_expired_out, 600, n);
		check(near(n, 256), 32'h1);
		$display("test pacing done");
		wr(cmt_pkg::IDX_NOISE_PRELOAD, 32'hFFFE);
		rd(cmt_pkg::IDX_PRESCALE, q);
		check(32'(q[9:8] != 2'b00), 32'h1);
		wr(cmt_pkg::IDX_NOISE_PRELOAD, 32'hFFFE);
		wait_hi(noise_expired_out, 40, n);
		check(near(n, 8), 32'h1);
		wr(cmt_pkg::IDX_CTRL_A, 32'h2);
		wr(cmt_pkg::IDX_NOISE_PRELOAD, 32'hFFF0);
		wait_hi(noise_expired_out, 60, n);
		check(near(n, 16), 32'h1);
		wr(cmt_pkg::IDX_CTRL_A, 32'h4);
		wr(cmt_pkg::IDX_NOISE_PRELOAD, 32'hFFF0);
		check(32'(host_access_error_out), 32'h1);
		rd(cmt_pkg::IDX_NOISE_COUNT, q);
		check(q, 32'h0);
		wr(cmt_pkg::IDX_EVENT, 32'h1);
		noise_limit_in <= 16'hFFF8;
		pulse(P_LEAVE);
		wait_hi(noise_expired_out, 100, n);
		check(near(n, 32), 32'h1);
		$display("test noise done");
		pcm_state_in <= cmt_pkg::PCM_ACTIVE;
		wr(cmt_pkg::IDX_CTRL_A, 32'h2);
		noise_limit_in <= 16'hFFF8;
		pulse(P_LEAVE);
		wait_hi(break_req_out, 40, n);
		check(32'(break_req_cause_out), 32'h3);
		pcm_state_in <= cmt_pkg::PCM_NEXT;
		response_expected_in <= 1'b1;
		wr(cmt_pkg::IDX_CTRL_A, 32'h1);
		pace_param_in <= 16'hFFF8;
		pulse(P_LOAD);
		wait_hi(break_req_out, 40, n);
		check(32'(break_req_cause_out), 32'h2);
		$display("test break done");
		results();
	end
endmodule : tb_top
bind cmt_conn_timers cmt_props i_props (.core_clk_in, .sys_rst_in,
	.psel_in, .penable_in, .pwrite_in, .paddr_in, .pready_out,
	.pcm_state_in, .response_expected_in, .line_idle_in,
	.line_state_seen_in, .rx_code_start_in, .tx_code_start_in,
	.signaling_out, .line_state_seen_out, .rx_code_started_out,
	.tx_code_started_out, .pace_expired_out, .noise_expired_out,
	.break_req_out, .break_req_cause_out, .host_access_error_out);
`default_nettype wire
